// ---- rtp_pdv_slip_offset_control.sv ----
// Per-connection slip offset control for received packet delay variation.
// Assumes all inputs come from logic clocked by MCLK; software-side pulses
// are one cycle wide and the structure fields are plain ports.
`include "pdv_params.svh"
module rtp_pdv_slip_offset_control
   import pdv_pkg::*;
#(
   parameter int TS_W    = `TS_WIDTH,
   parameter int SLIP_W  = `SLIP_WIDTH,
   parameter int FRAME_W = `FRAME_WIDTH,
   parameter int PTR_W   = `PTR_WIDTH
)(
   input  wire logic                     MCLK,
   input  wire logic                     RST,
   // Software side of the structure
   input  wire logic                     STRUCT_INIT,
   input  wire logic                     SET_RESET_ONCE,
   input  wire logic                     SET_RESET_SILENCE,
   input  wire logic                     SET_RESET_MARKER,
   input  wire logic                     RESET_ALWAYS,
   input  wire logic                     INIT_WITH_LEAD,
   input  wire min_slip_type             MIN_SLIP,
   input  wire logic signed [SLIP_W-1:0] MIN_DELAY,
   input  wire logic signed [SLIP_W-1:0] INIT_LEAD,
   input  wire logic        [TS_W-1:0]   DESIRED_DELTA,
   input  wire logic        [PTR_W-1:0]  OVERRUN_LEAD,
   // Packet path
   input  wire logic                     PKT_VALID,
   input  wire logic        [TS_W-1:0]   PKT_TS,
   input  wire logic                     PKT_HAS_RTP,
   input  wire logic                     PKT_MARKER,
   input  wire logic        [FRAME_W-1:0] PKT_FRAMES,
   input  wire logic        [FRAME_W-1:0] LOST_FRAMES,
   input  wire logic        [TS_W-1:0]   LOCAL_TS,
   // Slip events from the buffer logic
   input  wire logic                     SLIP_EVT,
   input  wire logic                     SLIP_OVERRUN,
   input  wire logic        [SLIP_W-1:0] SLIP_FRAMES,
   input  wire logic        [PTR_W-1:0]  TDM_RD_PTR,
   // Structure state written back
   output logic                          FLAG_RESET_ONCE,
   output logic                          FLAG_RESET_SILENCE,
   output logic                          FLAG_RESET_MARKER,
   output logic                          FIRST_PACKET_SEEN,
   output logic signed      [SLIP_W-1:0] SLIP_OFFSET,
   output logic             [TS_W-1:0]   LAST_REMOTE_TS,
   output logic             [TS_W-1:0]   LAST_LOCAL_TS,
   output logic             [TS_W-1:0]   LAST_DELTA,
   output logic             [TS_W-1:0]   PLAY_TS,
   output logic                          PKT_DONE,
   output cause_type                     LAST_CAUSE,
   output logic             [PTR_W-1:0]  WR_PTR,
   output logic                          WR_PTR_LOAD
);

   pdv_calc_if calc_bus ();

   logic                     once_reg, once_next;
   logic                     sil_reg, sil_next;
   logic                     mark_reg, mark_next;
   logic                     seen_reg, seen_next;
   logic signed [SLIP_W-1:0] slip_reg, slip_next;
   logic [TS_W-1:0]          remote_reg, local_reg, delta_reg, play_reg;
   logic [FRAME_W-1:0]       frames_reg;
   logic                     done_reg;
   cause_type                cause_reg, cause_next;
   logic [PTR_W-1:0]         wptr_reg;
   logic                     wload_reg;

   // Helper sees registered history and the current packet
   assign calc_bus.pkt_ts      = PKT_TS;
   assign calc_bus.has_rtp     = PKT_HAS_RTP;
   assign calc_bus.last_remote = remote_reg;
   assign calc_bus.last_frames = frames_reg;
   assign calc_bus.local_ts    = LOCAL_TS;
   assign calc_bus.min_slip    = MIN_SLIP;
   assign calc_bus.lost_frames = LOST_FRAMES;

   pdv_ts_calc i_pdv_ts_calc (
      .c (calc_bus.calc)
   );

   // Packet classification; a first packet never takes a reset request
   wire first_pkt  = PKT_VALID && !seen_reg;
   wire later_pkt  = PKT_VALID && seen_reg;
   wire hit_once   = later_pkt && once_reg;
   wire hit_sil    = later_pkt && sil_reg && calc_bus.silence_hit;
   wire hit_mark   = later_pkt && mark_reg && PKT_MARKER;
   wire hit_always = later_pkt && RESET_ALWAYS;
   wire do_reset   = hit_once || hit_sil || hit_mark || hit_always;
   wire init_lead  = first_pkt && INIT_WITH_LEAD;
   // Reset-always freezes the offset, so slips are not counted then
   wire slip_ok    = SLIP_EVT && !RESET_ALWAYS && !do_reset && !init_lead;
   wire signed [SLIP_W-1:0] lead_sum = MIN_DELAY + INIT_LEAD;
   wire signed [SLIP_W-1:0] slip_add = slip_reg + $signed(SLIP_FRAMES);
   wire signed [SLIP_W-1:0] slip_sub = slip_reg - $signed(SLIP_FRAMES);

   // Request flags: a software set in the clearing cycle survives
   assign once_next = (once_reg && !hit_once) || SET_RESET_ONCE;
   assign sil_next  = (sil_reg && !hit_sil) || SET_RESET_SILENCE;
   assign mark_next = (mark_reg && !hit_mark) || SET_RESET_MARKER;
   assign seen_next = STRUCT_INIT ? 1'b0 : (seen_reg || PKT_VALID);

   // Offset update priority: structure init, then first-packet lead, then reset request, then slip event
   always_comb begin
      slip_next  = slip_reg;
      cause_next = cause_reg;
      if (STRUCT_INIT) begin
         slip_next  = `SLIP_RESET_VAL;
         cause_next = CAUSE_NONE;
      end else if (init_lead) begin
         slip_next  = lead_sum;
         cause_next = CAUSE_INIT;
      end else if (do_reset) begin
         slip_next  = `SLIP_RESET_VAL;
         cause_next = CAUSE_RESET;
      end else if (slip_ok && SLIP_OVERRUN) begin
         slip_next  = slip_add;
         cause_next = CAUSE_OVERRUN;
      end else if (slip_ok) begin
         slip_next  = slip_sub;
         cause_next = CAUSE_UNDERRN;
      end
   end
   // A first packet without lead falls through unchanged: desired delta is trusted

   // Playout stamp: remote minus desired delta minus offset
   wire [TS_W-1:0] slip_ext = TS_W'(slip_next);
   wire [TS_W-1:0] play_next = calc_bus.eff_ts - DESIRED_DELTA - slip_ext;

   // Request flags and first-packet state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         once_reg <= 1'b0;
         sil_reg  <= 1'b0;
         mark_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else begin
         once_reg <= once_next;
         sil_reg  <= sil_next;
         mark_reg <= mark_next;
         seen_reg <= seen_next;
      end
   end

   // Slip offset and its cause
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         slip_reg  <= `SLIP_RESET_VAL;
         cause_reg <= CAUSE_NONE;
      end else begin
         slip_reg  <= slip_next;
         cause_reg <= cause_next;
      end
   end

   // Per-packet timestamp history
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         remote_reg <= `TS_RESET_VAL;
         local_reg  <= `TS_RESET_VAL;
         delta_reg  <= `TS_RESET_VAL;
         play_reg   <= `TS_RESET_VAL;
         frames_reg <= `FRAME_RESET_VAL;
      end else if (PKT_VALID) begin
         remote_reg <= calc_bus.eff_ts;
         local_reg  <= LOCAL_TS;
         delta_reg  <= calc_bus.delta;
         play_reg   <= play_next;
         frames_reg <= PKT_FRAMES;
      end
   end

   // Completion pulse and overrun write pointer reload
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         done_reg  <= 1'b0;
         wptr_reg  <= `PTR_RESET_VAL;
         wload_reg <= 1'b0;
      end else begin
         done_reg  <= PKT_VALID;
         wload_reg <= SLIP_EVT && SLIP_OVERRUN;
         if (SLIP_EVT && SLIP_OVERRUN) begin
            wptr_reg <= TDM_RD_PTR + OVERRUN_LEAD;
         end
      end
   end

   assign FLAG_RESET_ONCE    = once_reg;
   assign FLAG_RESET_SILENCE = sil_reg;
   assign FLAG_RESET_MARKER  = mark_reg;
   assign FIRST_PACKET_SEEN  = seen_reg;
   assign SLIP_OFFSET        = slip_reg;
   assign LAST_REMOTE_TS     = remote_reg;
   assign LAST_LOCAL_TS      = local_reg;
   assign LAST_DELTA         = delta_reg;
   assign PLAY_TS            = play_reg;
   assign PKT_DONE           = done_reg;
   assign LAST_CAUSE         = cause_reg;
   assign WR_PTR             = wptr_reg;
   assign WR_PTR_LOAD        = wload_reg;

   // Checks on the packet handling
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   AST_ONCE_ZERO:
      assert property (hit_once && !STRUCT_INIT |=> SLIP_OFFSET == 0)
      else $error("reset-once did not zero the slip offset");
   AST_SILENCE_ZERO:
      assert property (later_pkt && sil_reg && LOST_FRAMES >= (`SILENCE_BASE << MIN_SLIP)
                       && !STRUCT_INIT |=> SLIP_OFFSET == 0)
      else $error("silence gap did not zero the slip offset");
   AST_MARKER_SKIP:
      assert property (later_pkt && mark_reg && !PKT_MARKER && !once_reg && !RESET_ALWAYS
                       && !hit_sil && !SLIP_EVT && !STRUCT_INIT
                       |=> $stable(SLIP_OFFSET) && FLAG_RESET_MARKER)
      else $error("packet without marker acted on the marker request");
   AST_FLAG_CLEAR:
      assert property (hit_mark && !SET_RESET_MARKER |=> !FLAG_RESET_MARKER ##1 !FLAG_RESET_MARKER
                       || $past(SET_RESET_MARKER))
      else $error("marker request not cleared after use");
   AST_THRESH_TOP:
      assert property (MIN_SLIP == 3'h7 |-> calc_bus.threshold == 16'h0800)
      else $error("silence code 7 is not 2048 frames");
   AST_INIT_LEAD:
      assert property (init_lead && !STRUCT_INIT
                       |=> SLIP_OFFSET == $past(MIN_DELAY) + $past(INIT_LEAD))
      else $error("init lead not loaded on first packet");
   AST_INIT_PLAIN:
      assert property (first_pkt && !INIT_WITH_LEAD && !SLIP_EVT && !STRUCT_INIT
                       |=> $stable(SLIP_OFFSET))
      else $error("first packet without lead changed the offset");
   AST_SEEN:
      assert property (PKT_VALID && !STRUCT_INIT |=> FIRST_PACKET_SEEN && PKT_DONE)
      else $error("first packet not recorded");
   AST_NO_RTP:
      assert property (PKT_VALID && !PKT_HAS_RTP
                       |=> LAST_REMOTE_TS == $past(LAST_REMOTE_TS) + TS_W'($past(frames_reg)))
      else $error("emulated remote stamp did not advance");
   AST_OVR_ADD:
      assert property (slip_ok && SLIP_OVERRUN && !STRUCT_INIT
                       |=> SLIP_OFFSET == $past(slip_reg) + $signed($past(SLIP_FRAMES)))
      else $error("overrun frames not added to the offset");
   AST_DELTA:
      assert property (PKT_VALID && PKT_HAS_RTP |=> LAST_DELTA == LAST_REMOTE_TS - LAST_LOCAL_TS)
      else $error("delta is not remote minus local");
   AST_PLAY_ZERO:
      assert property (PKT_VALID && PKT_HAS_RTP && PKT_TS == 0 && DESIRED_DELTA == 0
                       && slip_next == 0 |=> PLAY_TS == 0)
      else $error("zero stamp at zero delta not played at local zero");
   AST_WR_PTR:
      assert property (SLIP_EVT && SLIP_OVERRUN
                       |=> WR_PTR_LOAD && WR_PTR == $past(TDM_RD_PTR) + $past(OVERRUN_LEAD))
      else $error("overrun did not reload the write pointer");
   AST_ALWAYS:
      assert property (RESET_ALWAYS && seen_reg && !STRUCT_INIT && !PKT_VALID
                       && SLIP_OFFSET == 0 |=> SLIP_OFFSET == 0)
      else $error("offset moved while reset-always is set");

   // Underrun frames come off the offset, so opposite slips cancel
   AST_UNDER_SUB:
      assert property (slip_ok && !SLIP_OVERRUN && !STRUCT_INIT
                       |=> SLIP_OFFSET == $past(slip_reg) - $signed($past(SLIP_FRAMES)))
      else $error("underrun frames not taken from the offset");
   // Each request clears after its own use unless software sets it again
   AST_ONCE_CLEAR:
      assert property (hit_once && !SET_RESET_ONCE |=> !FLAG_RESET_ONCE)
      else $error("reset-once request not cleared after use");
   AST_SIL_CLEAR:
      assert property (hit_sil && !SET_RESET_SILENCE |=> !FLAG_RESET_SILENCE)
      else $error("silence request not cleared after use");
   // A gap shorter than the threshold leaves the silence request armed
   AST_SIL_SHORT:
      assert property (later_pkt && sil_reg && LOST_FRAMES < (`SILENCE_BASE << MIN_SLIP)
                       |=> FLAG_RESET_SILENCE)
      else $error("short gap consumed the silence request");
   // The first packet never uses up a pending reset-once request
   AST_FIRST_KEEP:
      assert property (first_pkt && once_reg |=> FLAG_RESET_ONCE)
      else $error("first packet consumed the reset-once request");
   // Lowest code of the silence field
   AST_THRESH_LOW:
      assert property (MIN_SLIP == 3'h0 |-> calc_bus.threshold == 16'h0010)
      else $error("silence code 0 is not 16 frames");
   AST_REMOTE_RTP:
      assert property (PKT_VALID && PKT_HAS_RTP |=> LAST_REMOTE_TS == $past(PKT_TS))
      else $error("remote stamp of the packet not stored");
   // Playout follows the new offset on every packet, sign-extended
   AST_PLAY:
      assert property (PKT_VALID
                       |=> PLAY_TS == LAST_REMOTE_TS - $past(DESIRED_DELTA) - TS_W'(SLIP_OFFSET))
      else $error("playout stamp does not follow the slip offset");
   AST_CAUSE_RESET:
      assert property (do_reset && !STRUCT_INIT |=> LAST_CAUSE == CAUSE_RESET)
      else $error("reset request not recorded as the cause");
   // Completion is a one-cycle pulse per packet
   AST_DONE_PULSE:
      assert property (!PKT_VALID |=> !PKT_DONE)
      else $error("completion pulse without a packet");

   COV_ONCE:    cover property (hit_once ##1 PKT_DONE);
   COV_MARKER:  cover property (hit_mark && !hit_once);
   COV_SILENCE: cover property (hit_sil);
   COV_UNDER:   cover property (slip_ok && !SLIP_OVERRUN ##1 SLIP_OFFSET < 0);
   COV_INIT:    cover property (init_lead ##1 PKT_DONE);
endmodule

// ---- pdv_params.svh ----
// Constants for the receive delay-variation slip offset block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PDV_PARAMS_SVH
`define PDV_PARAMS_SVH
`define TS_WIDTH        32
`define SLIP_WIDTH      16
`define FRAME_WIDTH     16
`define PTR_WIDTH       12
`define SILENCE_BASE    16'h0010
`define SLIP_RESET_VAL  16'h0000
`define TS_RESET_VAL    32'h0000_0000
`define PTR_RESET_VAL   12'h000
`define FRAME_RESET_VAL 16'h0000
`endif

// ---- pdv_pkg.sv ----
// Types shared by the slip offset block and its timestamp helper.
// Assumes pdv_params.svh is on the include path.
`include "pdv_params.svh"
package pdv_pkg;
   typedef logic [2:0] min_slip_type;
   // Cause of the latest slip offset change, one-hot
   typedef enum logic [4:0] {
      CAUSE_NONE    = 5'h01,
      CAUSE_INIT    = 5'h02,
      CAUSE_RESET   = 5'h04,
      CAUSE_OVERRUN = 5'h08,
      CAUSE_UNDERRN = 5'h10
   } cause_type;
endpackage

// ---- pdv_calc_if.sv ----
// Carrier between the slip offset controller and its timestamp helper.
// Assumes both ends sit in one clock domain; the helper is combinational.
`include "pdv_params.svh"
interface pdv_calc_if;
   import pdv_pkg::*;
   logic [`TS_WIDTH-1:0]    pkt_ts;
   logic                    has_rtp;
   logic [`TS_WIDTH-1:0]    last_remote;
   logic [`FRAME_WIDTH-1:0] last_frames;
   logic [`TS_WIDTH-1:0]    local_ts;
   min_slip_type            min_slip;
   logic [`FRAME_WIDTH-1:0] lost_frames;
   logic [`TS_WIDTH-1:0]    eff_ts;
   logic [`TS_WIDTH-1:0]    delta;
   logic [`FRAME_WIDTH-1:0] threshold;
   logic                    silence_hit;
   modport ctrl (output pkt_ts, has_rtp, last_remote, last_frames, local_ts,
                 min_slip, lost_frames, input eff_ts, delta, threshold, silence_hit);
   modport calc (input pkt_ts, has_rtp, last_remote, last_frames, local_ts,
                 min_slip, lost_frames, output eff_ts, delta, threshold, silence_hit);
endinterface

// ---- pdv_ts_calc.sv ----
// Timestamp helper: effective remote stamp, remote/local delta, silence test.
// Assumes inputs are stable values of the controller's clock domain; only the history inputs are registered.
`include "pdv_params.svh"
module pdv_ts_calc
   import pdv_pkg::*;
(
   pdv_calc_if.calc c
);
   // Without RTP the stamp is emulated from the previous packet's frame count
   assign c.eff_ts = c.has_rtp ? c.pkt_ts
                   : c.last_remote + `TS_WIDTH'(c.last_frames);
   // Delta is remote minus local, wrapping like the stamps themselves
   assign c.delta = c.eff_ts - c.local_ts;
   // Threshold is 16 frames doubled per code step
   assign c.threshold = `SILENCE_BASE << c.min_slip;
   assign c.silence_hit = (c.lost_frames >= c.threshold);
endmodule

// ---- pdv_far_end_model.sv ----
// Far-end model: local bus timestamp source and buffer read pointer.
// Assumes one clock domain and a bench that drives on the falling edge.
module pdv_far_end_model
   import pdv_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  rst,
   output logic [31:0] local_ts,
   output logic [11:0] rd_ptr
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus stamp advances one frame per clock. The read pointer takes an odd
   // step so that wrap at twelve bits is reached quickly.
   always_ff @(negedge mclk or posedge rst) begin
      if (rst) begin
         local_ts <= 32'h0000_0000;
         rd_ptr   <= 12'h000;
      end else begin
         local_ts <= local_ts + 32'h0000_0001;
         rd_ptr   <= rd_ptr + 12'h007;
      end
   end
endmodule

// ---- test_rtp_pdv_slip_offset_control.sv ----
// Self-checking bench for the slip offset controller, with a reference model in tasks.
// Assumes the far-end model supplies the bus timestamp and the read pointer.
module test_rtp_pdv_slip_offset_control
   import pdv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 20000;
   logic               mclk, rst, s_init, set_o, set_s, set_m, r_always, lead_en;
   logic               pkt_v, has_rtp, marker, slip_evt, slip_ov, m_first;
   logic               f_o, f_s, f_m, first_seen, done, wr_load;
   min_slip_type       min_slip;
   logic signed [15:0] min_delay, init_lead, m_off, slip_off;
   logic        [31:0] delta_des, pkt_ts, local_ts, m_remote, lts;
   logic        [31:0] last_rem, last_loc, last_delta, play_ts;
   logic        [15:0] pkt_fr, lost, slip_fr, m_frames;
   logic        [11:0] ov_lead, rd_ptr, rd_cap, wr_ptr;
   logic        [2:0]  m_fl;
   logic        [4:0]  m_cause;
   cause_type          cause;
   integer             seed = 72511;
   int                 err_total, check_count, cycles, i, k;

   rtp_pdv_slip_offset_control i_rtp_pdv_slip_offset_control (
      .MCLK(mclk), .RST(rst), .STRUCT_INIT(s_init), .SET_RESET_ONCE(set_o),
      .SET_RESET_SILENCE(set_s), .SET_RESET_MARKER(set_m), .RESET_ALWAYS(r_always),
      .INIT_WITH_LEAD(lead_en), .MIN_SLIP(min_slip), .MIN_DELAY(min_delay),
      .INIT_LEAD(init_lead), .DESIRED_DELTA(delta_des), .OVERRUN_LEAD(ov_lead),
      .PKT_VALID(pkt_v), .PKT_TS(pkt_ts), .PKT_HAS_RTP(has_rtp), .PKT_MARKER(marker),
      .PKT_FRAMES(pkt_fr), .LOST_FRAMES(lost), .LOCAL_TS(local_ts), .SLIP_EVT(slip_evt),
      .SLIP_OVERRUN(slip_ov), .SLIP_FRAMES(slip_fr), .TDM_RD_PTR(rd_ptr),
      .FLAG_RESET_ONCE(f_o), .FLAG_RESET_SILENCE(f_s), .FLAG_RESET_MARKER(f_m),
      .FIRST_PACKET_SEEN(first_seen), .SLIP_OFFSET(slip_off), .LAST_REMOTE_TS(last_rem),
      .LAST_LOCAL_TS(last_loc), .LAST_DELTA(last_delta), .PLAY_TS(play_ts),
      .PKT_DONE(done), .LAST_CAUSE(cause), .WR_PTR(wr_ptr), .WR_PTR_LOAD(wr_load));

   pdv_far_end_model i_pdv_far_end_model (
      .mclk(mclk), .rst(rst), .local_ts(local_ts), .rd_ptr(rd_ptr));

   // Clock at 10 MHz
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Hang guard: the planned traffic needs well under a tenth of this
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Software initialises the structure; flags are left as they were
   task automatic init_struct(input logic lead);
      @(negedge mclk);
      {s_init, lead_en, delta_des} = {1'b1, lead, 32'h0000_0000};
      {m_first, m_off, m_cause} = {1'b0, 16'h0000, 5'h01};
      @(negedge mclk);
      s_init = 1'b0;
      chk("first", {31'h0, first_seen}, 32'h0);
      chk("cause", {27'h0, cause}, {27'h0, CAUSE_NONE});
   endtask

   // Request pulses; flags must be visible one cycle later
   task automatic req(input logic [2:0] r);
      @(negedge mclk);
      {set_o, set_s, set_m} = r;
      m_fl = m_fl | r;
      @(negedge mclk);
      {set_o, set_s, set_m} = 3'h0;
      chk("flags", {29'h0, f_o, f_s, f_m}, {29'h0, m_fl});
   endtask

   // Slip event; the read pointer is captured at the sampling edge
   task automatic slip(input logic ov, input logic [15:0] n);
      @(negedge mclk);
      {slip_evt, slip_ov, slip_fr} = {1'b1, ov, n};
      @(posedge mclk);
      rd_cap = rd_ptr;
      // Reset-always freezes both the offset and its recorded cause
      if (!r_always) begin
         m_off = ov ? m_off + n : m_off - n;
         m_cause = ov ? 5'h08 : 5'h10;
      end
      @(negedge mclk);
      slip_evt = 1'b0;
      chk("offset", {16'h0000, slip_off}, {16'h0000, m_off});
      chk("wr_load", {31'h0, wr_load}, {31'h0, ov});
      if (ov) chk("wr_ptr", {20'h0, wr_ptr}, {20'h0, 12'(rd_cap + ov_lead)});
      chk("cause", {27'h0, cause}, {27'h0, m_cause});
   endtask

   // One packet through the model and the design, then compare all packet outputs
   task automatic pkt(input logic rtp, input logic mk, input logic [31:0] ts,
                      input logic [15:0] fr, input logic [15:0] ls);
      logic [31:0] stamp;
      logic [31:0] thr;
      logic [2:0]  fired;
      @(negedge mclk);
      {pkt_v, has_rtp, marker, pkt_ts, pkt_fr, lost} = {1'b1, rtp, mk, ts, fr, ls};
      @(posedge mclk);
      lts = local_ts;
      stamp = rtp ? ts : m_remote + 32'(m_frames);
      thr = 32'h10 << min_slip;
      fired = {m_fl[2], m_fl[1] && (32'(ls) >= thr), m_fl[0] && mk};
      fired = m_first ? fired : 3'h0;
      if (!m_first && lead_en) begin
         m_off = min_delay + init_lead;
         m_cause = 5'h02;
      end else if (m_first && (fired != 3'h0 || r_always)) begin
         m_off = 16'h0000;
         m_cause = 5'h04;
      end
      m_fl = m_fl & ~fired;
      {m_first, m_remote, m_frames} = {1'b1, stamp, fr};
      @(negedge mclk);
      pkt_v = 1'b0;
      chk("done", {31'h0, done}, 32'h1);
      chk("first", {31'h0, first_seen}, 32'h1);
      chk("remote", last_rem, stamp);
      chk("local", last_loc, lts);
      chk("delta", last_delta, stamp - lts);
      chk("play", play_ts, stamp - delta_des - 32'(m_off));
      chk("offset", {16'h0000, slip_off}, {16'h0000, m_off});
      chk("flags", {29'h0, f_o, f_s, f_m}, {29'h0, m_fl});
      chk("cause", {27'h0, cause}, {27'h0, m_cause});
   endtask

   // Main sequence: corner cases first, then a random mix
   initial begin
      {rst, s_init, set_o, set_s, set_m, r_always, lead_en, pkt_v, has_rtp, marker} = 10'h200;
      {slip_evt, slip_ov, slip_fr, pkt_ts, pkt_fr, lost, delta_des, min_slip} = '0;
      {min_delay, init_lead, ov_lead, m_fl, m_first, m_off, m_remote, m_frames} = '0;
      m_cause = 5'h01;
      // Reset spans three rising edges before release
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      chk("rst_off", {16'h0000, slip_off}, 32'h0);
      chk("rst_cause", {27'h0, cause}, {27'h0, CAUSE_NONE});
      {min_delay, init_lead, ov_lead} = {16'($random(seed)), 16'($random(seed)), 12'hFF9};
      init_struct(1'b1);
      pkt(1'b1, 1'b0, 32'h0000_0000, 16'h00A0, 16'h0000);
      $display("test init with lead done");
      for (i = 0; i < 8; i++) slip(1'(i), 16'($random(seed)) & 16'h00FF);
      $display("test slips done");
      req(3'h4);
      pkt(1'b1, 1'b1, 32'h0000_0000, 16'h00A0, 16'h0000);
      slip(1'b1, 16'h0005);
      req(3'h1);
      pkt(1'b0, 1'b0, 32'h0000_0000, 16'h0050, 16'h0000);
      pkt(1'b0, 1'b1, 32'h0000_0000, 16'h0050, 16'h0000);
      $display("test once and marker done");
      for (k = 0; k < 8; k++) begin
         min_slip = 3'(k);
         slip(1'b1, 16'h0003);
         req(3'h2);
         pkt(1'b1, 1'b1, 32'($random(seed)), 16'h0010, (16'h0010 << k) - 16'h0001);
         pkt(1'b1, 1'b0, 32'($random(seed)), 16'h0010, 16'h0010 << k);
      end
      $display("test silence codes done");
      slip(1'b1, 16'h0007);
      r_always = 1'b1;
      slip(1'b0, 16'h0004);
      pkt(1'b1, 1'b0, 32'h0000_1234, 16'h0008, 16'h0000);
      slip(1'b1, 16'h0002);
      r_always = 1'b0;
      $display("test reset always done");
      init_struct(1'b0);
      slip(1'b0, 16'h0009);
      req(3'h4);
      pkt(1'b1, 1'b0, 32'h0000_0100, 16'h0008, 16'h0000);
      pkt(1'b1, 1'b0, 32'h0000_0108, 16'h0008, 16'h0000);
      $display("test init without lead done");
      delta_des = $random(seed);
      for (i = 0; i < 300; i++) begin
         min_slip = 3'($random(seed));
         r_always = (($random(seed) & 15) == 0);
         k = $random(seed) & 3;
         case (k)
            0: slip(1'($random(seed)), 16'($random(seed)) & 16'h00FF);
            1: req(3'($random(seed)));
            default: pkt(1'($random(seed)), 1'($random(seed)), $random(seed),
                          16'($random(seed)) & 16'h00FF, 16'($random(seed)) & 16'h0FFF);
         endcase
      end
      $display("test random mix done");
      print_verdict();
   end
endmodule
